// ==== design/dbx_pkg.sv ====
package dbx_pkg;

	// ==================================================
	// status flag bit positions
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ==================================================
	// cycle counts per instruction class
	localparam logic [1:0] CYC_ONE   = 2'h1;
	localparam logic [1:0] CYC_TWO   = 2'h2;
	localparam logic [1:0] CYC_THREE = 2'h3;

	// ==================================================
	// apb register map (byte addresses)
	localparam logic [11:0] ADDR_CMD    = 12'h000;
	localparam logic [11:0] ADDR_FLAGS  = 12'h004;
	localparam logic [11:0] ADDR_STATUS = 12'h008;
	localparam logic [11:0] ADDR_WREG   = 12'h100;
	localparam int          WREG_SHIFT  = 2;

	// ==================================================
	// command and status word field layout
	localparam int CMD_OP_LSB   = 24;
	localparam int CMD_REG_LSB  = 16;
	localparam int CMD_ARG_LSB  = 0;
	localparam int STAT_BUSY    = 0;
	localparam int STAT_CYC_LSB = 8;

	// pointer pair base registers and register zero
	localparam logic [4:0] PTR_X = 5'h1a;
	localparam logic [4:0] PTR_Y = 5'h1c;
	localparam logic [4:0] PTR_Z = 5'h1e;
	localparam logic [4:0] WREG_ZERO = 5'h00;

	// ==================================================
	// operations
	typedef enum logic [5:0] {
		OP_NOP, OP_SLEEP, OP_WDOG, OP_BREAK,
		OP_LD_DISP_Y, OP_LD_DISP_Z, OP_LD_DIRECT,
		OP_ST_DISP_Y, OP_ST_DISP_Z, OP_ST_DIRECT,
		OP_ST_X, OP_ST_XINC, OP_ST_XDEC,
		OP_ST_Y, OP_ST_YINC, OP_ST_YDEC,
		OP_ST_Z, OP_ST_ZINC, OP_ST_ZDEC,
		OP_LPM_R0, OP_LPM, OP_LPM_INC,
		OP_IN, OP_OUT, OP_PUSH, OP_POP,
		OP_IOBSET, OP_IOBCLR,
		OP_LSL, OP_LSR, OP_ROL, OP_ROR, OP_ASR, OP_SWAP,
		OP_FSET, OP_FCLR, OP_BST, OP_BLD
	} dbx_op_type;

	// memory side request bundle
	typedef struct packed {
		logic        dataRd;
		logic        dataWr;
		logic [15:0] dataAddr;
		logic [7:0]  dataWdata;
		logic        ioRd;
		logic        ioWr;
		logic [5:0]  ioAddr;
		logic [7:0]  ioWdata;
		logic        progRd;
		logic [15:0] progAddr;
	} dbx_mem_req_type;

endpackage

// ==== design/dbx_exec.sv ====
// How it works
// RQ1: displaced load/store, two cycles, flags kept
// RQ2: direct load/store one byte, two cycles
// RQ3: post-increment store: write, then pointer plus one
// RQ4: pre-decrement store: pointer minus one, then write
// RQ5: displaced store leaves pointer unchanged
// RQ6: program byte load, three cycles, optional increment
// RQ7: push/pop via stack, two cycles each
// RQ8: io bit set/clear, two cycles
// RQ9: rotate left through carry, flags updated
// RQ10: rotate right through carry, flags updated
// RQ11: bit into transfer flag only
// RQ12: transfer flag into register bit
// RQ13: flag set/clear touches one flag only
// RQ14: nop, sleep, watchdog, break one cycle each
// RQ15: shifts zero fill, arithmetic keeps bit7
// RQ16: nibble swap, one cycle, no flags
// RQ17: port in/out one cycle, no flags
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module dbx_exec (
	input  wire logic                    clock,
	input  wire logic                    rst_n,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	output dbx_pkg::dbx_mem_req_type     memReq,
	input  wire logic [7:0]              dataRdata,
	input  wire logic [7:0]              ioRdata,
	input  wire logic [7:0]              progRdata,
	output logic                         sleepReq,
	output logic                         wdogRestart,
	output logic                         breakReq
);

	// ==================================================
	// architectural state
	logic [7:0]             wreg_reg [32];
	logic [7:0]             flags_reg;
	logic [15:0]            sp_reg;
	logic                   busy_reg;
	logic [1:0]             cyc_reg;
	logic [1:0]             len_reg;
	dbx_pkg::dbx_op_type    op_reg;
	logic [4:0]             rd_reg;
	logic [15:0]            arg_reg;
	logic [31:0]            rdata_reg;
	logic [7:0]             lastCycles_reg;

	// ==================================================
	// apb decode
	wire        access    = psel & penable;
	wire        wrStrobe  = access & pwrite;
	wire        isCmd     = paddr == dbx_pkg::ADDR_CMD;
	wire        isFlags   = paddr == dbx_pkg::ADDR_FLAGS;
	wire        isStatus  = paddr == dbx_pkg::ADDR_STATUS;
	wire        isWreg    = paddr[11:8] == dbx_pkg::ADDR_WREG[11:8] && paddr[7] == 1'b0
	                        && paddr[1:0] == 2'h0;
	wire [4:0]  wregIdx   = paddr[6:2];
	wire        mapped    = isCmd | isFlags | isStatus | isWreg;
	wire        cmdWrite  = wrStrobe & isCmd & ~busy_reg;
	wire        swWregWr  = wrStrobe & isWreg & ~busy_reg;
	wire        swFlagWr  = wrStrobe & isFlags & ~busy_reg;

	assign pready  = 1'b1;
	assign pslverr = access & (~mapped | (pwrite & (isStatus | (busy_reg & ~isCmd))));
	assign prdata  = rdata_reg;

	// new command fields
	wire dbx_pkg::dbx_op_type newOp  = dbx_pkg::dbx_op_type'(pwdata[dbx_pkg::CMD_OP_LSB +: 6]);
	wire [4:0]                newRd  = pwdata[dbx_pkg::CMD_REG_LSB +: 5];
	wire [15:0]               newArg = pwdata[dbx_pkg::CMD_ARG_LSB +: 16];

	// ==================================================
	// operand selection
	wire [7:0]  rdVal  = wreg_reg[rd_reg];
	wire [15:0] ptrX   = {wreg_reg[dbx_pkg::PTR_X + 5'h1], wreg_reg[dbx_pkg::PTR_X]};
	wire [15:0] ptrY   = {wreg_reg[dbx_pkg::PTR_Y + 5'h1], wreg_reg[dbx_pkg::PTR_Y]};
	wire [15:0] ptrZ   = {wreg_reg[dbx_pkg::PTR_Z + 5'h1], wreg_reg[dbx_pkg::PTR_Z]};
	wire        carry  = flags_reg[dbx_pkg::FLAG_C];
	wire [2:0]  bitSel = arg_reg[2:0];
	wire        lastCyc = busy_reg & (cyc_reg == len_reg);

	// cycle length per operation
	function automatic logic [1:0] opLen(input dbx_pkg::dbx_op_type op);
		case (op)
			dbx_pkg::OP_LPM_R0, dbx_pkg::OP_LPM, dbx_pkg::OP_LPM_INC: opLen = dbx_pkg::CYC_THREE;
			dbx_pkg::OP_LD_DISP_Y, dbx_pkg::OP_LD_DISP_Z, dbx_pkg::OP_LD_DIRECT,
			dbx_pkg::OP_ST_DISP_Y, dbx_pkg::OP_ST_DISP_Z, dbx_pkg::OP_ST_DIRECT,
			dbx_pkg::OP_ST_X, dbx_pkg::OP_ST_XINC, dbx_pkg::OP_ST_XDEC,
			dbx_pkg::OP_ST_Y, dbx_pkg::OP_ST_YINC, dbx_pkg::OP_ST_YDEC,
			dbx_pkg::OP_ST_Z, dbx_pkg::OP_ST_ZINC, dbx_pkg::OP_ST_ZDEC,
			dbx_pkg::OP_PUSH, dbx_pkg::OP_POP,
			dbx_pkg::OP_IOBSET, dbx_pkg::OP_IOBCLR: opLen = dbx_pkg::CYC_TWO;
			default: opLen = dbx_pkg::CYC_ONE;
		endcase
	endfunction

	// ==================================================
	// effective address and pointer update
	logic [15:0] effAddr;
	logic        ptrUpd;
	logic [4:0]  ptrBase;
	logic [15:0] ptrNew;
	always_comb begin
		effAddr = 16'h0000;
		ptrUpd  = 1'b0;
		ptrBase = dbx_pkg::PTR_X;
		ptrNew  = 16'h0000;
		case (op_reg)
			// RQ1 RQ5 displacement, pointer kept
			dbx_pkg::OP_LD_DISP_Y, dbx_pkg::OP_ST_DISP_Y: effAddr = ptrY + arg_reg;
			dbx_pkg::OP_LD_DISP_Z, dbx_pkg::OP_ST_DISP_Z: effAddr = ptrZ + arg_reg;
			// RQ2 direct address
			dbx_pkg::OP_LD_DIRECT, dbx_pkg::OP_ST_DIRECT: effAddr = arg_reg;
			dbx_pkg::OP_ST_X: effAddr = ptrX;
			dbx_pkg::OP_ST_Y: effAddr = ptrY;
			dbx_pkg::OP_ST_Z: effAddr = ptrZ;
			// RQ3 write old pointer, then increment
			dbx_pkg::OP_ST_XINC: begin
				effAddr = ptrX;
				ptrUpd  = 1'b1;
				ptrNew  = ptrX + 16'h0001;
			end
			dbx_pkg::OP_ST_YINC: begin
				effAddr = ptrY;
				ptrUpd  = 1'b1;
				ptrBase = dbx_pkg::PTR_Y;
				ptrNew  = ptrY + 16'h0001;
			end
			dbx_pkg::OP_ST_ZINC: begin
				effAddr = ptrZ;
				ptrUpd  = 1'b1;
				ptrBase = dbx_pkg::PTR_Z;
				ptrNew  = ptrZ + 16'h0001;
			end
			// RQ4 decrement, then write new pointer
			dbx_pkg::OP_ST_XDEC: begin
				effAddr = ptrX - 16'h0001;
				ptrUpd  = 1'b1;
				ptrNew  = effAddr;
			end
			dbx_pkg::OP_ST_YDEC: begin
				effAddr = ptrY - 16'h0001;
				ptrUpd  = 1'b1;
				ptrBase = dbx_pkg::PTR_Y;
				ptrNew  = effAddr;
			end
			dbx_pkg::OP_ST_ZDEC: begin
				effAddr = ptrZ - 16'h0001;
				ptrUpd  = 1'b1;
				ptrBase = dbx_pkg::PTR_Z;
				ptrNew  = effAddr;
			end
			// RQ6 program byte at z pointer
			dbx_pkg::OP_LPM_R0, dbx_pkg::OP_LPM: effAddr = ptrZ;
			dbx_pkg::OP_LPM_INC: begin
				effAddr = ptrZ;
				ptrUpd  = 1'b1;
				ptrBase = dbx_pkg::PTR_Z;
				ptrNew  = ptrZ + 16'h0001;
			end
			// RQ7 push writes at sp then decrements, pop pre-increments
			dbx_pkg::OP_PUSH: effAddr = sp_reg;
			dbx_pkg::OP_POP: effAddr = sp_reg + 16'h0001;
			default: effAddr = arg_reg;
		endcase
	end

	// ==================================================
	// memory strobes: writes on the final cycle, reads on cycle 1
	wire isLoad  = op_reg == dbx_pkg::OP_LD_DISP_Y || op_reg == dbx_pkg::OP_LD_DISP_Z
	               || op_reg == dbx_pkg::OP_LD_DIRECT || op_reg == dbx_pkg::OP_POP;
	wire isStore = (op_reg >= dbx_pkg::OP_ST_DISP_Y && op_reg <= dbx_pkg::OP_ST_ZDEC)
	               || op_reg == dbx_pkg::OP_PUSH;
	wire isLpm   = op_reg == dbx_pkg::OP_LPM_R0 || op_reg == dbx_pkg::OP_LPM
	               || op_reg == dbx_pkg::OP_LPM_INC;
	wire isIoBit = op_reg == dbx_pkg::OP_IOBSET || op_reg == dbx_pkg::OP_IOBCLR;
	// io read-modify-write: read in cycle 1, write in cycle 2
	wire ioRdNow = busy_reg & ((isIoBit & ~lastCyc) | (op_reg == dbx_pkg::OP_IN));
	wire ioWrNow = lastCyc & (isIoBit | op_reg == dbx_pkg::OP_OUT);
	logic [7:0] ioBitMask;
	assign ioBitMask = 8'h01 << bitSel;
	logic [7:0] ioHold_reg;

	always_comb begin
		memReq           = '0;
		memReq.dataAddr  = effAddr;
		memReq.dataWdata = rdVal;
		memReq.dataRd    = busy_reg & isLoad & ~lastCyc;
		memReq.dataWr    = lastCyc & isStore;
		memReq.ioAddr    = arg_reg[5:0];
		memReq.ioRd      = ioRdNow;
		memReq.ioWr      = ioWrNow;
		// RQ8 force selected bit
		memReq.ioWdata   = (op_reg == dbx_pkg::OP_IOBSET) ? (ioHold_reg | ioBitMask) :
		                   (op_reg == dbx_pkg::OP_IOBCLR) ? (ioHold_reg & ~ioBitMask) : rdVal;
		memReq.progRd    = busy_reg & isLpm & (cyc_reg == dbx_pkg::CYC_ONE);
		memReq.progAddr  = effAddr;
	end

	// ==================================================
	// shift unit result and flags
	logic [7:0] aluRes;
	logic       aluC;
	always_comb begin
		aluRes = rdVal;
		aluC   = carry;
		case (op_reg)
			// RQ15 zero fill, sign kept
			dbx_pkg::OP_LSL: {aluC, aluRes} = {rdVal, 1'b0};
			dbx_pkg::OP_LSR: {aluRes, aluC} = {1'b0, rdVal};
			dbx_pkg::OP_ASR: {aluRes, aluC} = {rdVal[7], rdVal};
			// RQ9 rotate left through carry
			dbx_pkg::OP_ROL: {aluC, aluRes} = {rdVal, carry};
			// RQ10 rotate right through carry
			dbx_pkg::OP_ROR: {aluRes, aluC} = {carry, rdVal};
			// RQ16 nibble exchange
			dbx_pkg::OP_SWAP: aluRes = {rdVal[3:0], rdVal[7:4]};
			// RQ12 transfer flag into bit
			dbx_pkg::OP_BLD: aluRes = (rdVal & ~ioBitMask) | ({8{flags_reg[dbx_pkg::FLAG_T]}}
			                          & ioBitMask);
			default: aluRes = rdVal;
		endcase
	end
	wire isShift = op_reg >= dbx_pkg::OP_LSL && op_reg <= dbx_pkg::OP_ASR;
	wire shN     = aluRes[7];
	wire shV     = shN ^ aluC;

	// next flags
	logic [7:0] flagsNext;
	always_comb begin
		flagsNext = flags_reg;
		if (swFlagWr) begin
			flagsNext = pwdata[7:0];
		end else if (lastCyc && isShift) begin
			flagsNext[dbx_pkg::FLAG_C] = aluC;
			flagsNext[dbx_pkg::FLAG_Z] = aluRes == 8'h00;
			flagsNext[dbx_pkg::FLAG_N] = shN;
			flagsNext[dbx_pkg::FLAG_V] = shV;
		end else if (lastCyc && op_reg == dbx_pkg::OP_BST) begin
			// RQ11 only transfer flag
			flagsNext[dbx_pkg::FLAG_T] = rdVal[bitSel];
		end else if (lastCyc && op_reg == dbx_pkg::OP_FSET) begin
			// RQ13 single flag set
			flagsNext[bitSel] = 1'b1;
		end else if (lastCyc && op_reg == dbx_pkg::OP_FCLR) begin
			// RQ13 single flag clear
			flagsNext[bitSel] = 1'b0;
		end
	end

	// register write-back selection
	wire wbAlu  = lastCyc & (isShift | op_reg == dbx_pkg::OP_SWAP | op_reg == dbx_pkg::OP_BLD);
	wire wbData = lastCyc & isLoad;
	wire wbIo   = lastCyc & (op_reg == dbx_pkg::OP_IN);
	wire wbProg = lastCyc & isLpm;
	// RQ6 no operand targets work_reg_zero
	wire [4:0] wbIdx = (op_reg == dbx_pkg::OP_LPM_R0) ? dbx_pkg::WREG_ZERO : rd_reg;
	logic [7:0] progHold_reg;
	logic [7:0] dataHold_reg;

	// ==================================================
	// sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			cyc_reg  <= 2'h0;
			len_reg  <= 2'h0;
			op_reg   <= dbx_pkg::OP_NOP;
			rd_reg   <= 5'h00;
			arg_reg  <= 16'h0000;
		end else if (cmdWrite) begin
			busy_reg <= 1'b1;
			cyc_reg  <= dbx_pkg::CYC_ONE;
			len_reg  <= opLen(newOp);
			op_reg   <= newOp;
			rd_reg   <= newRd;
			arg_reg  <= newArg;
		end else if (lastCyc) begin
			busy_reg <= 1'b0;
		end else if (busy_reg) begin
			cyc_reg <= cyc_reg + 2'h1;
		end
	end

	// captured read data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ioHold_reg   <= 8'h00;
			progHold_reg <= 8'h00;
			dataHold_reg <= 8'h00;
		end else begin
			if (ioRdNow) ioHold_reg <= ioRdata;
			if (memReq.progRd) progHold_reg <= progRdata;
			if (memReq.dataRd) dataHold_reg <= dataRdata;
		end
	end

	// RQ14 control pulses, one cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sleepReq    <= 1'b0;
			wdogRestart <= 1'b0;
			breakReq    <= 1'b0;
		end else begin
			sleepReq    <= lastCyc & (op_reg == dbx_pkg::OP_SLEEP);
			wdogRestart <= lastCyc & (op_reg == dbx_pkg::OP_WDOG);
			breakReq    <= lastCyc & (op_reg == dbx_pkg::OP_BREAK);
		end
	end

	// flags and stack pointer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= 8'h00;
			sp_reg    <= 16'h0000;
		end else begin
			flags_reg <= flagsNext;
			// RQ7 stack pointer moves
			if (lastCyc && op_reg == dbx_pkg::OP_PUSH) sp_reg <= sp_reg - 16'h0001;
			else if (lastCyc && op_reg == dbx_pkg::OP_POP) sp_reg <= effAddr;
		end
	end

	// register file writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 32; i++) wreg_reg[i] <= 8'h00;
		end else if (swWregWr) begin
			wreg_reg[wregIdx] <= pwdata[7:0];
		end else begin
			// RQ17 port in
			if (wbIo) wreg_reg[rd_reg] <= ioRdata;
			if (wbAlu) wreg_reg[rd_reg] <= aluRes;
			if (wbData) wreg_reg[rd_reg] <= dataHold_reg;
			if (wbProg) wreg_reg[wbIdx] <= progHold_reg;
			// RQ3 pointer update after access
			if (lastCyc && ptrUpd) begin
				wreg_reg[ptrBase] <= ptrNew[7:0];
				wreg_reg[ptrBase + 5'h1] <= ptrNew[15:8];
			end
		end
	end

	// apb read data
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg      <= 32'h0000_0000;
			lastCycles_reg <= 8'h00;
		end else begin
			if (lastCyc) lastCycles_reg <= {6'h00, len_reg};
			if (psel && !penable && !pwrite) begin
				if (isFlags) rdata_reg <= {24'h000000, flags_reg};
				else if (isStatus) rdata_reg <= {16'h0000, lastCycles_reg, 7'h00, busy_reg};
				else if (isWreg) rdata_reg <= {24'h000000, wreg_reg[wregIdx]};
				else if (isCmd) rdata_reg <= {2'h0, op_reg, 3'h0, rd_reg, arg_reg};
				else rdata_reg <= 32'h0000_0000;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/dbx_exec_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// port checker
module dbx_exec_chk (
	input  wire logic                     clock,
	input  wire logic                     rst_n,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	input  wire logic [31:0]              prdata,
	input  wire logic                     pready,
	input  wire logic                     pslverr,
	input  wire dbx_pkg::dbx_mem_req_type memReq,
	input  wire logic [7:0]               dataRdata,
	input  wire logic [7:0]               ioRdata,
	input  wire logic [7:0]               progRdata,
	input  wire logic                     sleepReq,
	input  wire logic                     wdogRestart,
	input  wire logic                     breakReq
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	// ==================================================
	// bus answer and strobe timing
	chk_ready_high: assert property (pready)
		else $error("pready low");
	chk_err_phase: assert property (pslverr |-> psel && penable)
		else $error("error outside access phase");
	chk_load_strobe: assert property (memReq.dataRd |=> !memReq.dataRd && !memReq.dataWr)
		else $error("load strobe too long");
	chk_store_strobe: assert property (memReq.dataWr |=> !memReq.dataWr)
		else $error("store strobe too long");
	chk_prog_gap: assert property (memReq.progRd |=> (!memReq.progRd) [*2])
		else $error("program read repeated");
	// io bit op: same place, at most one bit changed
	chk_iobit_one: assert property (memReq.ioWr && $past(memReq.ioRd) |->
		memReq.ioAddr == $past(memReq.ioAddr) &&
		$countones(memReq.ioWdata ^ $past(ioRdata)) <= 1)
		else $error("io bit op changed more than one bit");
	chk_sleep_pulse: assert property (sleepReq |=> !sleepReq)
		else $error("sleep pulse too long");
	chk_mcu_excl: assert property (sleepReq |-> !wdogRestart && !breakReq)
		else $error("control pulses overlap");
	chk_wdog_pulse: assert property (wdogRestart |=> !wdogRestart)
		else $error("watchdog pulse too long");
endmodule
`default_nettype wire

// ==== test/dbx_mem_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// data, io and program memories
module dbx_mem_model (
	input  wire logic                     clock,
	input  wire dbx_pkg::dbx_mem_req_type memReq,
	output logic      [7:0]               dataRdata,
	output logic      [7:0]               ioRdata,
	output logic      [7:0]               progRdata
);
	logic [7:0] dmem  [65536];
	logic [7:0] iomem [64];
	logic [7:0] pmem  [65536];
	logic [7:0] junk = 8'h5a;
	// writes land at the edge ending the strobe
	always @(posedge clock) begin
		junk <= ~junk;
		if (memReq.dataWr) dmem[memReq.dataAddr] <= memReq.dataWdata;
		if (memReq.ioWr) iomem[memReq.ioAddr] <= memReq.ioWdata;
	end
	// data only while strobed, else a toggling pattern
	assign dataRdata = memReq.dataRd ? dmem[memReq.dataAddr] : junk;
	assign ioRdata   = memReq.ioRd ? iomem[memReq.ioAddr] : junk;
	assign progRdata = memReq.progRd ? pmem[memReq.progAddr] : ~junk;
endmodule
`default_nettype wire

// ==== test/test_data_bit_instruction_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==================================================
// bench top
module test_data_bit_instruction_exec;
	logic                    clock = 1'b0;
	logic                    rst_n = 1'b0;
	logic                    psel = 1'b0;
	logic                    penable = 1'b0;
	logic                    pwrite = 1'b0;
	logic [11:0]             paddr = 12'h000;
	logic [31:0]             pwdata = 32'h0;
	logic [31:0]             prdata;
	logic                    pready, pslverr, sleepReq, wdogRestart, breakReq;
	dbx_pkg::dbx_mem_req_type memReq;
	logic [7:0]              dataRdata, ioRdata, progRdata;
	logic [7:0]              wr [32];
	logic [7:0]              dm [65536];
	logic [7:0]              pm [65536];
	logic [7:0]              io [64];
	logic [7:0]              fl = 8'h00;
	logic [15:0]             sp = 16'h0;
	logic [15:0]             lastA = 16'h0;
	logic [5:0]              lastIo = 6'h0;
	logic [31:0]             q;
	logic                    e;
	int                      err_count = 0, check_count = 0, cycles = 0, nPulse[3] = '{0, 0, 0};
	int                      i, k, o;

	dbx_exec u_dbx_exec (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .memReq(memReq), .dataRdata(dataRdata), .ioRdata(ioRdata),
		.progRdata(progRdata), .sleepReq(sleepReq), .wdogRestart(wdogRestart),
		.breakReq(breakReq));
	dbx_mem_model u_dbx_mem_model (.clock(clock), .memReq(memReq), .dataRdata(dataRdata),
		.ioRdata(ioRdata), .progRdata(progRdata));

	always #4 clock = ~clock;
	// pulse counts and hang limit
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (sleepReq === 1'b1) nPulse[0] <= nPulse[0] + 1;
		if (wdogRestart === 1'b1) nPulse[1] <= nPulse[1] + 1;
		if (breakReq === 1'b1) nPulse[2] <= nPulse[2] + 1;
		if (cycles == 40000) begin
			err_count = err_count + 1;
			wrap_up();
		end
	end

	task wrap_up;
		if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	// one apb transfer, held until pready at an edge
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	function logic [7:0] cyc(input dbx_pkg::dbx_op_type op);
		if (op >= dbx_pkg::OP_LPM_R0 && op <= dbx_pkg::OP_LPM_INC) return 8'(dbx_pkg::CYC_THREE);
		if (op >= dbx_pkg::OP_LD_DISP_Y && op <= dbx_pkg::OP_ST_ZDEC) return 8'(dbx_pkg::CYC_TWO);
		if (op >= dbx_pkg::OP_PUSH && op <= dbx_pkg::OP_IOBCLR) return 8'(dbx_pkg::CYC_TWO);
		return 8'(dbx_pkg::CYC_ONE);
	endfunction

	task st(input logic [15:0] a, input logic [7:0] v);
		dm[a] = v;
		lastA = a;
	endtask

	// reference behaviour of every operation
	task model(input dbx_pkg::dbx_op_type op, input logic [4:0] rd, input logic [15:0] arg,
		output logic [7:0] m);
		logic [7:0] v;
		logic c;
		logic [4:0] pb;
		logic [15:0] p, y, z;
		int n;
		v = wr[rd];
		c = fl[0];
		m = 8'hff;
		y = {wr[29], wr[28]};
		z = {wr[31], wr[30]};
		lastIo = arg[5:0];
		n = int'(op) - int'(dbx_pkg::OP_ST_X);
		pb = 5'(26 + 2 * (n / 3));
		p = {wr[pb + 5'h1], wr[pb]};
		if (n >= 0 && n < 9) begin
			if (n % 3 == 2) p = p - 16'h1;
			st(p, v);
			if (n % 3 == 1) p = p + 16'h1;
			{wr[pb + 5'h1], wr[pb]} = p;
		end
		case (op)
			dbx_pkg::OP_LD_DISP_Y: wr[rd] = dm[y + arg];
			dbx_pkg::OP_LD_DISP_Z: wr[rd] = dm[z + arg];
			dbx_pkg::OP_LD_DIRECT: wr[rd] = dm[arg];
			dbx_pkg::OP_ST_DISP_Y: st(y + arg, v);
			dbx_pkg::OP_ST_DISP_Z: st(z + arg, v);
			dbx_pkg::OP_ST_DIRECT: st(arg, v);
			dbx_pkg::OP_LPM_R0: wr[0] = pm[z];
			dbx_pkg::OP_LPM: wr[rd] = pm[z];
			dbx_pkg::OP_LPM_INC: {wr[31], wr[30], wr[rd]} = {z + 16'h1, pm[z]};
			dbx_pkg::OP_IN: wr[rd] = io[arg[5:0]];
			dbx_pkg::OP_OUT: io[arg[5:0]] = v;
			dbx_pkg::OP_PUSH: begin
				st(sp, v);
				sp = sp - 16'h1;
			end
			dbx_pkg::OP_POP: {sp, wr[rd]} = {sp + 16'h1, dm[sp + 16'h1]};
			dbx_pkg::OP_IOBSET: io[arg[5:0]][arg[2:0]] = 1'b1;
			dbx_pkg::OP_IOBCLR: io[arg[5:0]][arg[2:0]] = 1'b0;
			dbx_pkg::OP_LSL: {c, v} = {v, 1'b0};
			dbx_pkg::OP_LSR: {v, c} = {1'b0, v};
			dbx_pkg::OP_ROL: {c, v} = {v, fl[0]};
			dbx_pkg::OP_ROR: {v, c} = {fl[0], v};
			dbx_pkg::OP_ASR: {v, c} = {v[7], v};
			dbx_pkg::OP_SWAP: wr[rd] = {v[3:0], v[7:4]};
			dbx_pkg::OP_FSET: fl[arg[2:0]] = 1'b1;
			dbx_pkg::OP_FCLR: fl[arg[2:0]] = 1'b0;
			dbx_pkg::OP_BST: fl[dbx_pkg::FLAG_T] = v[arg[2:0]];
			dbx_pkg::OP_BLD: wr[rd][arg[2:0]] = fl[dbx_pkg::FLAG_T];
			default: ;
		endcase
		if (op >= dbx_pkg::OP_LSL && op <= dbx_pkg::OP_ASR) begin
			wr[rd] = v;
			fl[3:0] = {v[7] ^ c, v[7], v == 8'h00, c};
		end
	endtask

	task issue(input dbx_pkg::dbx_op_type op, input logic [4:0] rd, input logic [15:0] arg);
		apb(1'b1, dbx_pkg::ADDR_CMD, {2'h0, op, 3'h0, rd, arg});
		chk({31'h0, e}, 32'h0);
	endtask

	// wait for idle, then compare length, register file, flags and memories
	task finish(input dbx_pkg::dbx_op_type op, input logic [4:0] rd, input logic [15:0] arg);
		logic [7:0] m;
		do apb(1'b0, dbx_pkg::ADDR_STATUS, 32'h0); while (q[dbx_pkg::STAT_BUSY] !== 1'b0);
		chk({24'h0, q[15:8]}, {24'h0, cyc(op)});
		model(op, rd, arg, m);
		for (int j = 0; j < 32; j++) begin
			apb(1'b0, dbx_pkg::ADDR_WREG + 12'(4 * j), 32'h0);
			chk({24'h0, q[7:0]}, {24'h0, wr[j]});
		end
		apb(1'b0, dbx_pkg::ADDR_FLAGS, 32'h0);
		chk({24'h0, q[7:0] & m}, {24'h0, fl & m});
		chk({24'h0, u_dbx_mem_model.dmem[lastA]}, {24'h0, dm[lastA]});
		chk({24'h0, u_dbx_mem_model.iomem[lastIo]}, {24'h0, io[lastIo]});
	endtask

	task exec(input int op, input logic [15:0] arg);
		logic [4:0] rd;
		rd = 5'($urandom % 26);
		issue(dbx_pkg::dbx_op_type'(op), rd, arg);
		finish(dbx_pkg::dbx_op_type'(op), rd, arg);
	endtask

	task setfl(input logic [7:0] v);
		apb(1'b1, dbx_pkg::ADDR_FLAGS, {24'h0, v});
		fl = v;
	endtask

	// ==================================================
	// main sequence
	initial begin
		void'($urandom(32'h4d92));
		for (i = 0; i < 65536; i++) begin
			dm[i] = 8'($urandom);
			pm[i] = 8'($urandom);
			u_dbx_mem_model.dmem[i] = dm[i];
			u_dbx_mem_model.pmem[i] = pm[i];
			if (i < 64) {io[i], u_dbx_mem_model.iomem[i]} = {2{i[7:0] ^ 8'h3c}};
		end
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		for (i = 0; i < 32; i++) begin
			wr[i] = 8'($urandom);
			apb(1'b1, dbx_pkg::ADDR_WREG + 12'(4 * i), {24'h0, wr[i]});
		end
		// shifts, rotates and swap from random flags
		for (k = 0; k < 8; k++)
			for (o = dbx_pkg::OP_LSL; o <= dbx_pkg::OP_SWAP; o++) begin
				setfl(8'($urandom));
				exec(o, 16'h0);
			end
		// every flag set and cleared, bit moves
		for (k = 0; k < 8; k++) begin
			exec(dbx_pkg::OP_FSET, 16'(k));
			exec(dbx_pkg::OP_FCLR, 16'(k));
			exec(dbx_pkg::OP_BST, 16'($urandom % 8));
			exec(dbx_pkg::OP_BLD, 16'($urandom % 8));
		end
		// loads, stores, program bytes, port moves, stack
		for (k = 0; k < 2; k++)
			for (o = dbx_pkg::OP_LD_DISP_Y; o <= dbx_pkg::OP_POP; o++)
				exec(o, 16'($urandom % 64));
		for (k = 0; k < 4; k++) begin
			i = $urandom % 64;
			exec(dbx_pkg::OP_IOBSET + k % 2, {5'h0, i[2:0], 2'h0, i[5:0]});
		end
		for (o = dbx_pkg::OP_NOP; o <= dbx_pkg::OP_BREAK; o++) exec(o, 16'h0);
		chk(nPulse[0] + nPulse[1] * 16 + nPulse[2] * 256, 32'h111);
		// refused accesses while busy and to odd places
		setfl(8'h00);
		for (k = 0; k < 2; k++) begin
			issue(dbx_pkg::OP_LPM, 5'h3, 16'h0);
			if (k == 0) apb(1'b1, dbx_pkg::ADDR_FLAGS, 32'hff);
			else apb(1'b1, dbx_pkg::ADDR_CMD, {2'h0, dbx_pkg::OP_FSET, 24'h0});
			chk({31'h0, e}, {31'h0, k == 0});
			finish(dbx_pkg::OP_LPM, 5'h3, 16'h0);
		end
		apb(1'b1, dbx_pkg::ADDR_STATUS, 32'h0);
		chk({31'h0, e}, 32'h1);
		apb(1'b0, 12'h00c, 32'h0);
		chk({31'h0, e}, 32'h1);
		wrap_up();
	end
endmodule

bind dbx_exec dbx_exec_chk u_chk (.clock(clock), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .memReq(memReq), .dataRdata(dataRdata),
	.ioRdata(ioRdata), .progRdata(progRdata), .sleepReq(sleepReq),
	.wdogRestart(wdogRestart), .breakReq(breakReq));
`default_nettype wire
